// File: cbr_bridge_regs.sv
`timescale 1ns/1ps
//Contract
//[RULE_01] per-function line register, resets ff
//[RULE_02] tie set: pin reads 01 both
//[RULE_03] tie clear: pin 01 fn0, 02 fn1
//[RULE_04] software sets serial stream before tie
//[RULE_05] control resets 0340, reserved bits zero
//[RULE_06] bit 10 per socket write posting
//[RULE_07] bit 9 window 1 prefetchable
//[RULE_08] bit 8 window 0 prefetchable
//[RULE_09] bit 7 routes card functional interrupts
//[RULE_10] bit 6 or host reset resets card
//[RULE_11] bit 5 reports card master aborts
//[RULE_12] bit 3 forwards vga ranges
//[RULE_13] bit 2 blocks isa alias io
//[RULE_14] bit 1 forwards card serr
//[RULE_15] bit 0 read-only parity response
//[RULE_16] global bits written through function 0; writes through function 1 reach them too
//[RULE_17] memory windows bounded by base/limit; no base/limit registers here, only the bit 9 and bit 8 prefetchable flags
//[RULE_18] socket bits per function, global shared
module cbr_bridge_regs
    import cbr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire cbr_cfg_req_t i_cfg,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    input wire logic i_interrupt_tie_select,
    output cbr_sock_ctl_t [1:0] o_sock_ctl,
    output logic [1:0] o_card_reset_b,
    output logic o_master_abort_report_mode,
    output logic o_card_syserr_forward_enable,
    output logic o_card_parity_response_enable,
    input wire logic [1:0] i_card_master_abort,
    input wire logic i_host_serr_enable,
    output logic [1:0] o_host_target_abort,
    output logic o_host_syserr,
    input wire logic [1:0] i_card_syserr,
    input wire logic [1:0] i_card_parity_err,
    output logic [1:0] o_card_parity_report,
    input wire logic [31:0] i_fwd_addr,
    input wire logic i_fwd_is_io,
    output logic [1:0] o_vga_forward,
    output logic [1:0] o_isa_block
);
    logic [1:0][7:0] irq_line;
    logic [1:0][7:0] next_irq_line;
    logic [1:0][15:0] ctrl_sock;
    logic [1:0][15:0] next_ctrl_sock;
    logic [15:0] ctrl_glob;
    logic [15:0] next_ctrl_glob;
    logic next_ack;
    logic [31:0] next_rdata;
    logic [7:0] pin_value;
    logic [15:0] ctrl_view;
    logic [15:0] wr_ctrl;
    logic bank_hit;
    cbr_sock_ctl_t [1:0] next_sock_ctl;
    logic [1:0] next_card_reset_b;
    logic [1:0] next_target_abort;
    logic next_host_syserr;
    logic [1:0] next_parity_report;

    // configuration access decode, writes and read mux
    always_comb
    begin
        bank_hit = i_cfg.req && i_cfg.dword == CBR_BANK_DWORD;
        next_irq_line = irq_line;
        next_ctrl_sock = ctrl_sock;
        next_ctrl_glob = ctrl_glob;
        wr_ctrl = ctrl_sock[i_cfg.func] | ctrl_glob;
        if (i_cfg.be[2])
            wr_ctrl[7:0] = i_cfg.wdata[23:16];
        if (i_cfg.be[3])
            wr_ctrl[15:8] = i_cfg.wdata[31:24];
        if (bank_hit && i_cfg.wr)
        begin
            if (i_cfg.be[0])
                next_irq_line[i_cfg.func] = i_cfg.wdata[7:0]; // [RULE_01]
            // byte lane 1 is the read-only pin register: ignored
            next_ctrl_sock[i_cfg.func] = wr_ctrl & CBR_CTRL_SOCK_MASK; // [RULE_18]
            // either function reaches the shared copy; software keeps to function 0
            next_ctrl_glob = (ctrl_glob & ~CBR_CTRL_GLOB_WMASK) | (wr_ctrl & CBR_CTRL_GLOB_WMASK); // [RULE_16]
        end
        // tie forces the first interrupt for both functions
        if (i_interrupt_tie_select || !i_cfg.func) // [RULE_04]
            pin_value = CBR_PIN_FIRST; // [RULE_02]
        else
            pin_value = CBR_PIN_SECOND; // [RULE_03]
        ctrl_view = (ctrl_sock[i_cfg.func] & CBR_CTRL_SOCK_MASK) | (ctrl_glob & CBR_CTRL_GLOB_MASK); // [RULE_05]
        next_ack = i_cfg.req;
        next_rdata = 32'h0000_0000;
        if (bank_hit && !i_cfg.wr)
            next_rdata = {ctrl_view, pin_value, irq_line[i_cfg.func]};
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_line <= {2{CBR_IRQ_LINE_RST}};
            ctrl_sock <= {2{CBR_CTRL_RST & CBR_CTRL_SOCK_MASK}}; // [RULE_05]
            ctrl_glob <= CBR_CTRL_RST & CBR_CTRL_GLOB_MASK;
            o_cfg_ack <= 1'b0;
            o_cfg_rdata <= 32'h0000_0000;
        end
        else
        begin
            irq_line <= next_irq_line;
            ctrl_sock <= next_ctrl_sock;
            ctrl_glob <= next_ctrl_glob;
            o_cfg_ack <= next_ack;
            o_cfg_rdata <= next_rdata;
        end
    end

    // control word fanned out to the bridge datapath, one register late
    always_comb
    begin
        for (int s = 0; s < 2; s++)
        begin
            next_sock_ctl[s].write_post_enable = ctrl_sock[s][CBR_BIT_POST]; // [RULE_06]
            next_sock_ctl[s].window1_prefetchable = ctrl_sock[s][CBR_BIT_PF1]; // [RULE_07] [RULE_17]
            next_sock_ctl[s].window0_prefetchable = ctrl_sock[s][CBR_BIT_PF0]; // [RULE_08] [RULE_17]
            next_sock_ctl[s].functional_irq_route_select = ctrl_sock[s][CBR_BIT_ROUTE]; // [RULE_09]
            next_sock_ctl[s].vga_forward_enable = ctrl_sock[s][CBR_BIT_VGA]; // [RULE_12]
            next_sock_ctl[s].isa_range_filter_enable = ctrl_sock[s][CBR_BIT_ISA]; // [RULE_13]
            next_card_reset_b[s] = !ctrl_sock[s][CBR_BIT_CRST]; // [RULE_10]
            // abort reported only in report mode; serr still needs host enable
            next_target_abort[s] = i_card_master_abort[s] && ctrl_glob[CBR_BIT_MABT]; // [RULE_11]
            next_parity_report[s] = i_card_parity_err[s] && ctrl_glob[CBR_BIT_CPERR]; // [RULE_15]
        end
        next_host_syserr = (|i_card_syserr && ctrl_glob[CBR_BIT_CSERR]) || // [RULE_14]
                           (|i_card_master_abort && ctrl_glob[CBR_BIT_MABT] && i_host_serr_enable); // [RULE_11]
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_sock_ctl <= '0;
            o_card_reset_b <= 2'b00; // host reset holds both cards in reset [RULE_10]
            o_master_abort_report_mode <= 1'b0;
            o_card_syserr_forward_enable <= 1'b0;
            o_card_parity_response_enable <= 1'b0;
            o_host_target_abort <= 2'b00;
            o_host_syserr <= 1'b0;
            o_card_parity_report <= 2'b00;
        end
        else
        begin
            o_sock_ctl <= next_sock_ctl;
            o_card_reset_b <= next_card_reset_b;
            o_master_abort_report_mode <= ctrl_glob[CBR_BIT_MABT];
            o_card_syserr_forward_enable <= ctrl_glob[CBR_BIT_CSERR];
            o_card_parity_response_enable <= ctrl_glob[CBR_BIT_CPERR];
            o_host_target_abort <= next_target_abort;
            o_host_syserr <= next_host_syserr;
            o_card_parity_report <= next_parity_report;
        end
    end

    // one range decoder per socket
    for (genvar s = 0; s < 2; s++)
    begin : g_sock
        cbr_fwd_decode u_decode (
            .i_core_clk(i_core_clk),
            .i_rst_b(i_rst_b),
            .i_addr(i_fwd_addr),
            .i_is_io(i_fwd_is_io),
            .i_vga_enable(o_sock_ctl[s].vga_forward_enable),
            .i_isa_enable(o_sock_ctl[s].isa_range_filter_enable),
            .o_vga_forward(o_vga_forward[s]),
            .o_isa_block(o_isa_block[s])
        );
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    // host leaves one idle cycle between requests, so the readback comes two cycles on
    a_line_write: assert property ( // [RULE_01]
        i_cfg.req && i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_cfg.be[0]
        ##2 i_cfg.req && !i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_cfg.func == $past(i_cfg.func, 2)
        |=> o_cfg_rdata[7:0] == $past(i_cfg.wdata[7:0], 3))
        else $error("line register readback wrong");
    a_pin_tied: assert property ( // [RULE_02]
        i_cfg.req && !i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_interrupt_tie_select
        |=> o_cfg_rdata[15:8] == 8'h01)
        else $error("tied pin value wrong");
    a_pin_split: assert property ( // [RULE_03]
        i_cfg.req && !i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && !i_interrupt_tie_select
        |=> o_cfg_rdata[15:8] == ($past(i_cfg.func) ? 8'h02 : 8'h01))
        else $error("untied pin value wrong");
    a_ctrl_reserved: assert property ( // [RULE_05]
        o_cfg_ack |-> o_cfg_rdata[31:27] == 5'h00 && !o_cfg_rdata[20] && !o_cfg_rdata[16])
        else $error("reserved control bits not zero");
    a_post_follow: assert property ( // [RULE_06]
        i_cfg.req && i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_cfg.be[3] && !i_cfg.func
        |-> ##2 o_sock_ctl[0].write_post_enable == $past(i_cfg.wdata[26], 2))
        else $error("posting enable not taken");
    a_card_reset: assert property ( // [RULE_10]
        i_cfg.req && i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_cfg.be[2] && i_cfg.func
        |-> ##2 o_card_reset_b[1] == !$past(i_cfg.wdata[22], 2))
        else $error("card reset not following bit 6");
    a_abort_report: assert property ( // [RULE_11]
        i_card_master_abort[0] |=> o_host_target_abort[0] == $past(ctrl_glob[5]))
        else $error("master abort report mismatch");
    a_serr_block: assert property ( // [RULE_14]
        !ctrl_glob[1] && !ctrl_glob[5] |=> !o_host_syserr)
        else $error("card serr leaked");
    a_parity_quiet: assert property ( // [RULE_15]
        o_card_parity_report == 2'b00 && !o_card_parity_response_enable)
        else $error("parity response bit writable");
    a_route_glob: assert property ( // [RULE_18]
        i_cfg.req && i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_cfg.be[2] && i_cfg.func
        |=> ctrl_glob[1] == $past(i_cfg.wdata[17]) && ctrl_sock[0] == $past(ctrl_sock[0]))
        else $error("shared or per-function copy wrong");

    c_ctrl_write: cover property (i_cfg.req && i_cfg.wr && i_cfg.dword == CBR_BANK_DWORD && i_cfg.be[3]);
    c_pin_tied: cover property (i_cfg.req && !i_cfg.wr && i_cfg.func && i_interrupt_tie_select);
    c_abort_out: cover property (o_host_target_abort[0] && o_host_syserr);
    c_card_run: cover property (o_card_reset_b == 2'b11);
endmodule

// File: cbr_bridge_regs_tb_top.sv
`timescale 1ns/1ps
module cbr_bridge_regs_tb_top
    import cbr_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    cbr_cfg_req_t cfg;
    logic tie = 1'b0, serr_en = 1'b0, is_io = 1'b0;
    logic [1:0] abort = 2'h0, syserr = 2'h0, perr = 2'h0;
    logic [31:0] addr = 32'h0;
    logic ack, mabt, cserr, cperr, host_serr;
    logic [31:0] rdata;
    cbr_sock_ctl_t [1:0] sock;
    logic [1:0] crst_b, tabort, prep, vga, isa;
    int n_fail = 0;
    int n_tests = 0;

    always #5 i_core_clk = ~i_core_clk;

    cbr_host_model host (.i_core_clk(i_core_clk), .o_cfg(cfg));

    cbr_bridge_regs uut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cfg(cfg), .o_cfg_ack(ack),
        .o_cfg_rdata(rdata), .i_interrupt_tie_select(tie), .o_sock_ctl(sock), .o_card_reset_b(crst_b),
        .o_master_abort_report_mode(mabt), .o_card_syserr_forward_enable(cserr),
        .o_card_parity_response_enable(cperr), .i_card_master_abort(abort), .i_host_serr_enable(serr_en),
        .o_host_target_abort(tabort), .o_host_syserr(host_serr), .i_card_syserr(syserr),
        .i_card_parity_err(perr), .o_card_parity_report(prep), .i_fwd_addr(addr), .i_fwd_is_io(is_io),
        .o_vga_forward(vga), .o_isa_block(isa));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    // ack must stand in the cycle right after the request
    task automatic rd(input logic fn, input logic [5:0] dw, input logic [31:0] exp);
        host.issue(1'b0, fn, dw, 4'h0, 32'h0);
        chk({31'h0, ack}, 32'h1);
        chk(rdata, exp);
    endtask

    task automatic wr(input logic fn, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
        host.issue(1'b1, fn, dw, be, wd);
        chk({31'h0, ack}, 32'h1);
    endtask

    task automatic s_reset;
        rd(1'b0, 6'h0f, 32'h0340_01ff);
        rd(1'b1, 6'h0f, 32'h0340_02ff);
        chk({20'h0, sock}, 32'h618);
        chk({30'h0, crst_b}, 32'h0);
    endtask

    task automatic s_tie;
        @(negedge i_core_clk);
        tie = 1'b1; // serial stream taken as already routed
        rd(1'b1, 6'h0f, 32'h0340_01ff);
        rd(1'b0, 6'h0f, 32'h0340_01ff);
        tie = 1'b0;
    endtask

    // control half all ones: reserved, read-only and pin bytes must not take the write
    task automatic s_write;
        wr(1'b1, 6'h0f, 4'hf, 32'hffff_a55a);
        rd(1'b1, 6'h0f, 32'h07ee_025a);
        rd(1'b0, 6'h0f, 32'h0362_01ff);
        chk({20'h0, sock}, 32'hfd8);
        chk({27'h0, crst_b, mabt, cserr, cperr}, 32'h06);
        wr(1'b1, 6'h0f, 4'h4, 32'h0);
        rd(1'b1, 6'h0f, 32'h0700_025a);
        rd(1'b0, 6'h0f, 32'h0340_01ff);
        chk({30'h0, crst_b}, 32'h2);
    endtask

    // gating of card events by the shared control bits
    task automatic s_events;
        // upper lane too, so socket 0 posting enable gets exercised
        wr(1'b0, 6'h0f, 4'hc, 32'h072e_0000);
        rd(1'b1, 6'h0f, 32'h0722_025a);
        serr_en = 1'b1;
        abort = 2'h1;
        @(negedge i_core_clk);
        chk({27'h0, tabort, host_serr, prep}, 32'h0c);
        abort = 2'h0;
        syserr = 2'h2;
        perr = 2'h3;
        @(negedge i_core_clk);
        chk({27'h0, tabort, host_serr, prep}, 32'h04);
        serr_en = 1'b0;
        syserr = 2'h0;
        abort = 2'h2;
        @(negedge i_core_clk);
        chk({27'h0, tabort, host_serr, prep}, 32'h10);
        abort = 2'h0;
        perr = 2'h0;
    endtask

    // socket 0 has both filters on, socket 1 has them off
    task automatic s_decode;
        logic [31:0] a[5] = '{32'h300, 32'h3c0, 32'ha0000, 32'h50, 32'h10300};
        logic io[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        logic [3:0] e[5] = '{4'h1, 4'h5, 4'h4, 4'h0, 4'h0};
        for (int i = 0; i < 5; i++)
        begin
            addr = a[i];
            is_io = io[i];
            @(negedge i_core_clk);
            chk({28'h0, vga, isa}, {28'h0, e[i]});
        end
    endtask

    task automatic s_unmapped;
        rd(1'b0, 6'h00, 32'h0);
        wr(1'b0, 6'h10, 4'hf, 32'hffff_ffff);
        rd(1'b0, 6'h0f, 32'h072e_01ff);
    endtask

    // host reset in mid-run must put cards back into reset
    task automatic s_rereset;
        @(negedge i_core_clk);
        i_rst_b = 1'b0;
        #1;
        chk({30'h0, crst_b}, 32'h0);
        @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rd(1'b1, 6'h0f, 32'h0340_02ff);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reset held for 20 cycles, then scenarios in sequence
    initial
    begin
        repeat (20) @(posedge i_core_clk);
        chk({30'h0, crst_b}, 32'h0);
        @(negedge i_core_clk);
        i_rst_b = 1'b1;
        s_reset();
        s_tie();
        s_write();
        s_events();
        s_decode();
        s_unmapped();
        s_rereset();
        wrap_up();
    end
endmodule

// File: cbr_fwd_decode.sv
`timescale 1ns/1ps
module cbr_fwd_decode
    import cbr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [31:0] i_addr,
    input wire logic i_is_io,
    input wire logic i_vga_enable,
    input wire logic i_isa_enable,
    output logic o_vga_forward,
    output logic o_isa_block
);
    logic next_vga_forward;
    logic next_isa_block;
    logic vga_hit;

    // vga window and isa alias decode
    always_comb
    begin
        if (i_is_io)
            vga_hit = (i_addr >= CBR_VGA_IO0_LO && i_addr <= CBR_VGA_IO0_HI) ||
                      (i_addr >= CBR_VGA_IO1_LO && i_addr <= CBR_VGA_IO1_HI);
        else
            vga_hit = i_addr >= CBR_VGA_MEM_LO && i_addr <= CBR_VGA_MEM_HI;
        next_vga_forward = i_vga_enable && vga_hit; // [RULE_12]
        // top 768 bytes of each 1k block below 64k are the isa aliases
        next_isa_block = i_isa_enable && i_is_io && i_addr < CBR_ISA_TOP && i_addr[9:8] != 2'b00; // [RULE_13]
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_vga_forward <= 1'b0;
            o_isa_block <= 1'b0;
        end
        else
        begin
            o_vga_forward <= next_vga_forward;
            o_isa_block <= next_isa_block;
        end
    end

    a_isa_alias: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_13]
        (i_isa_enable && i_is_io && i_addr[15:0] == 16'h0300 && i_addr[31:16] == 16'h0000)
        |=> o_isa_block)
        else $error("isa alias not blocked");
endmodule

// File: cbr_host_model.sv
`timescale 1ns/1ps
// host side issuing configuration cycles, one request cycle at a time
module cbr_host_model
    import cbr_pkg::*;
(
    input wire logic i_core_clk,
    output cbr_cfg_req_t o_cfg
);
    initial
    begin
        o_cfg = '0;
    end

    // launched off the falling edge, taken at the next rising edge
    // idle bus shows inverted leftovers so no stale value can pass for a request
    task automatic issue(input logic wr, input logic fn, input logic [5:0] dw, input logic [3:0] be,
                         input logic [31:0] wd);
        @(negedge i_core_clk);
        o_cfg = '{req: 1'b1, wr: wr, func: fn, dword: dw, be: be, wdata: wd};
        @(negedge i_core_clk);
        o_cfg = '{req: 1'b0, wr: ~wr, func: ~fn, dword: ~dw, be: ~be, wdata: ~wd};
    endtask
endmodule

// File: cbr_pkg.sv
package cbr_pkg;

    // configuration space placement of the bank
    localparam logic [7:0] CBR_OFS_IRQ_LINE = 8'h3c;
    localparam logic [7:0] CBR_OFS_IRQ_PIN = 8'h3d;
    localparam logic [7:0] CBR_OFS_CTRL = 8'h3e;
    localparam logic [5:0] CBR_BANK_DWORD = CBR_OFS_IRQ_LINE[7:2];

    // values after reset and fixed read values
    localparam logic [7:0] CBR_IRQ_LINE_RST = 8'hff;
    localparam logic [7:0] CBR_PIN_FIRST = 8'h01;
    localparam logic [7:0] CBR_PIN_SECOND = 8'h02;
    localparam logic [15:0] CBR_CTRL_RST = 16'h0340;

    // control word layout
    localparam logic [15:0] CBR_CTRL_SOCK_MASK = 16'h07cc;
    localparam logic [15:0] CBR_CTRL_GLOB_WMASK = 16'h0022;
    localparam logic [15:0] CBR_CTRL_GLOB_MASK = 16'h0023;
    localparam int CBR_BIT_POST = 10;
    localparam int CBR_BIT_PF1 = 9;
    localparam int CBR_BIT_PF0 = 8;
    localparam int CBR_BIT_ROUTE = 7;
    localparam int CBR_BIT_CRST = 6;
    localparam int CBR_BIT_MABT = 5;
    localparam int CBR_BIT_VGA = 3;
    localparam int CBR_BIT_ISA = 2;
    localparam int CBR_BIT_CSERR = 1;
    localparam int CBR_BIT_CPERR = 0;

    // forwarding ranges
    localparam logic [31:0] CBR_ISA_TOP = 32'h0001_0000;
    localparam logic [31:0] CBR_VGA_MEM_LO = 32'h000a_0000;
    localparam logic [31:0] CBR_VGA_MEM_HI = 32'h000b_ffff;
    localparam logic [31:0] CBR_VGA_IO0_LO = 32'h0000_03b0;
    localparam logic [31:0] CBR_VGA_IO0_HI = 32'h0000_03bb;
    localparam logic [31:0] CBR_VGA_IO1_LO = 32'h0000_03c0;
    localparam logic [31:0] CBR_VGA_IO1_HI = 32'h0000_03df;

    typedef struct packed {
        logic req;
        logic wr;
        logic func;
        logic [5:0] dword;
        logic [3:0] be;
        logic [31:0] wdata;
    } cbr_cfg_req_t;

    typedef struct packed {
        logic write_post_enable;
        logic window1_prefetchable;
        logic window0_prefetchable;
        logic functional_irq_route_select;
        logic vga_forward_enable;
        logic isa_range_filter_enable;
    } cbr_sock_ctl_t;

endpackage
